// File: logic/ram_block_consts.svh
// constants for the configurable embedded ram block
// assumes inclusion by logic/configurable_embedded_ram.sv only
`ifndef RAM_BLOCK_CONSTS_SVH
`define RAM_BLOCK_CONSTS_SVH
// storage capacity per block size, parity bits included
`define RAM_SMALL_BITS 576
`define RAM_MEDIUM_BITS 4608
`define RAM_LARGE_BITS 589824
// byte lanes: nine bits when widths carry parity, else eight
`define RAM_LANE_PARITY 9
`define RAM_LANE_PLAIN 8
`define RAM_BE_W 16
`define RAM_MAX_W 144
// register bus
`define RAM_AXI_AW 12
`define RAM_CTRL_OFS 12'h000
`define RAM_STATUS_OFS 12'h004
`define RAM_CONFIG_OFS 12'h008
`define RAM_CTRL_OLD_BIT 0
`define RAM_CTRL_RESET 1'h0
`define RAM_RESP_OKAY 2'h0
`define RAM_RESP_SLVERR 2'h2
`define RAM_CNT_W 16
`endif

// File: logic/ram_types_pkg.sv
// types shared by the embedded ram block
// assumes nothing beyond a SystemVerilog compiler
package ram_types_pkg;
  typedef enum logic [1:0] {SIZE_SMALL, SIZE_MEDIUM, SIZE_LARGE} block_size_t;
  typedef enum logic [1:0] {
    MODE_TRUE_DUAL, MODE_SIMPLE_DUAL, MODE_SINGLE, MODE_TWO_SINGLE
  } port_mode_t;
endpackage

// File: logic/configurable_embedded_ram.sv
// configurable embedded ram block with register access over axi4-lite
// assumes fabric user logic on mclk drives both ports synchronously
//
// Added by the designer: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "ram_block_consts.svh"

// Contract
// R1 - three sizes: 32x18, 128x36, 4Kx144 widest
// R2 - medium and large allow true dual-port
// R3 - all port inputs captured in input registers
// R4 - write strobe generated internally from clock
// R5 - optional output register, bypass is combinational
// R6 - flow-through reads via falling-edge read registers
// R7 - same-address read during write: old or fill
// R8 - single-port: written data visible on read output; the output register loads the pre-write word, bypass shows the new
// R9 - ports may have different data widths
// R10 - medium block splits into two half memories
// R11 - parity bit stored with every byte
// R12 - byte enables mask writes on medium, large
// R13 - large block ROM needs user write then hold
// R14 - clear hits inputs and outputs, large outputs only
// R15 - size, mode, depth, width fixed at build
module configurable_embedded_ram
  import ram_types_pkg::*;
#(
  parameter block_size_t SIZE = SIZE_MEDIUM,
  parameter port_mode_t MODE = MODE_TRUE_DUAL,
  parameter int A_W = 36,
  parameter int A_AW = 7,
  parameter int B_W = 36,
  parameter int B_AW = 7,
  parameter bit OUT_REG = 1'b1,
  parameter bit FLOW_THROUGH = 1'b0
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic a_clken,
  input wire logic [A_AW-1:0] a_addr,
  input wire logic [A_W-1:0] a_wdata,
  input wire logic [`RAM_BE_W-1:0] a_be,
  input wire logic a_we,
  input wire logic a_re,
  output logic [A_W-1:0] a_rdata,
  input wire logic b_clken,
  input wire logic [B_AW-1:0] b_addr,
  input wire logic [B_W-1:0] b_wdata,
  input wire logic [`RAM_BE_W-1:0] b_be,
  input wire logic b_we,
  input wire logic b_re,
  output logic [B_W-1:0] b_rdata,
  input wire logic [`RAM_AXI_AW-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [`RAM_AXI_AW-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready
);

  // capacity of each size; widest shapes are 32x18, 128x36, 4Kx144
  function automatic int cap_bits(block_size_t s);
    unique case (s)
      SIZE_SMALL: cap_bits = `RAM_SMALL_BITS; // see R1
      SIZE_MEDIUM: cap_bits = `RAM_MEDIUM_BITS; // see R1
      SIZE_LARGE: cap_bits = `RAM_LARGE_BITS; // see R1
    endcase
  endfunction

  // bit mask from byte enables; nine-bit lanes keep parity with its byte
  function automatic logic [`RAM_MAX_W-1:0] lane_mask(
    logic [`RAM_BE_W-1:0] be, int w);
    int lane;
    lane = (w % `RAM_LANE_PARITY == 0) ? `RAM_LANE_PARITY : `RAM_LANE_PLAIN;
    lane_mask = '0;
    for (int i = 0; i < w; i++) begin
      lane_mask[i] = be[i / lane]; // see R11 see R12
    end
  endfunction

  // shape fixed at build time; mixed widths share narrow units
  localparam int NW = (A_W < B_W) ? A_W : B_W; // see R15 see R9
  localparam int A_N = A_W / NW;
  localparam int B_N = B_W / NW;
  localparam int UNITS = cap_bits(SIZE) / NW;
  localparam int IW = $clog2(UNITS);
  localparam int WN_SH = $clog2((A_N > B_N) ? A_N : B_N);
  localparam bit IS_LARGE = (SIZE == SIZE_LARGE);
  // small block has no true dual-port; it falls back to simple dual
  localparam port_mode_t EMODE = (MODE == MODE_TRUE_DUAL &&
    SIZE == SIZE_SMALL) ? MODE_SIMPLE_DUAL : MODE; // see R2
  localparam bit FLOW = FLOW_THROUGH && EMODE == MODE_SIMPLE_DUAL &&
    !IS_LARGE;
  localparam bit CLR_IN = !IS_LARGE;
  localparam bit BE_OK = (SIZE != SIZE_SMALL);

  logic [UNITS-1:0][NW-1:0] mem; // no preload: rom is written once, see R13
  logic [A_AW-1:0] a_addr_q;
  logic [A_W-1:0] a_wdata_q;
  logic [`RAM_BE_W-1:0] a_be_q;
  logic a_we_q, a_re_q;
  logic [B_AW-1:0] b_addr_q;
  logic [B_W-1:0] b_wdata_q;
  logic [`RAM_BE_W-1:0] b_be_q;
  logic b_we_q, b_re_q;
  logic [A_W-1:0] a_rdata_reg, a_rd_raw;
  logic [B_W-1:0] b_rdata_reg, b_rd_raw;
  logic ctrl_old_reg;
  logic [`RAM_CNT_W-1:0] coll_cnt_reg;

  // port permissions per mode
  wire a_we_ok = 1'b1;
  wire a_re_ok = (EMODE != MODE_SIMPLE_DUAL);
  wire b_we_ok = (EMODE == MODE_TRUE_DUAL || EMODE == MODE_TWO_SINGLE);
  wire b_re_ok = (EMODE != MODE_SINGLE);
  wire a_wreq = a_clken && a_we && a_we_ok;
  wire b_wreq = b_clken && b_we && b_we_ok;
  // large block clear leaves the input registers alone
  wire in_clr_b = CLR_IN ? rst_b : 1'b1; // see R14

  // port a input registers
  always_ff @(posedge mclk or negedge in_clr_b) begin
    if (!in_clr_b) begin
      a_addr_q <= '0;
      a_wdata_q <= '0;
      a_be_q <= '0;
      a_we_q <= 1'b0;
      a_re_q <= 1'b0;
    end else if (a_clken) begin
      a_addr_q <= a_addr; // see R3
      a_wdata_q <= a_wdata; // see R3
      a_be_q <= a_be;
      a_we_q <= a_wreq;
      a_re_q <= a_re && a_re_ok;
    end else begin
      a_we_q <= 1'b0;
      a_re_q <= 1'b0;
    end
  end

  // port b write side always on the rising edge
  always_ff @(posedge mclk or negedge in_clr_b) begin
    if (!in_clr_b) begin
      b_wdata_q <= '0;
      b_be_q <= '0;
      b_we_q <= 1'b0;
    end else begin
      b_wdata_q <= b_clken ? b_wdata : b_wdata_q; // see R3
      b_be_q <= b_clken ? b_be : b_be_q;
      b_we_q <= b_wreq;
    end
  end

  // port b read address: falling edge gives flow-through reads
  generate
    if (FLOW) begin : g_flow
      always_ff @(negedge mclk or negedge in_clr_b) begin
        if (!in_clr_b) begin
          b_addr_q <= '0;
          b_re_q <= 1'b0;
        end else begin
          b_addr_q <= b_clken ? b_addr : b_addr_q; // see R6
          b_re_q <= b_clken && b_re && b_re_ok; // see R6
        end
      end
    end else begin : g_rise
      always_ff @(posedge mclk or negedge in_clr_b) begin
        if (!in_clr_b) begin
          b_addr_q <= '0;
          b_re_q <= 1'b0;
        end else begin
          b_addr_q <= b_clken ? b_addr : b_addr_q; // see R3
          b_re_q <= b_clken && b_re && b_re_ok;
        end
      end
    end
  endgenerate

  // split mode pins each port to its own half of the array
  wire split = (EMODE == MODE_TWO_SINGLE);
  wire [A_AW-1:0] a_addr_eff = split ?
    {1'b0, a_addr_q[A_AW-2:0]} : a_addr_q; // see R10
  wire [B_AW-1:0] b_addr_eff = split ?
    {1'b1, b_addr_q[B_AW-2:0]} : b_addr_q; // see R10
  wire [IW-1:0] a_base = IW'(a_addr_eff * A_N);
  wire [IW-1:0] b_base = IW'(b_addr_eff * B_N);

  // internal strobe: one cycle after capture, no user timing needed
  wire a_wr_strobe = a_we_q; // see R4
  wire b_wr_strobe = b_we_q; // see R4
  wire [A_W-1:0] a_mask =
    A_W'(lane_mask(BE_OK ? a_be_q : '1, A_W)); // see R12
  wire [B_W-1:0] b_mask =
    B_W'(lane_mask(BE_OK ? b_be_q : '1, B_W)); // see R12

  // array write; b is applied last, so b wins a same-unit clash
  always_ff @(posedge mclk) begin
    for (int k = 0; k < A_N; k++) begin
      if (a_wr_strobe) begin
        mem[a_base + IW'(k)] <= (mem[a_base + IW'(k)] & ~a_mask[k*NW +: NW])
          | (a_wdata_q[k*NW +: NW] & a_mask[k*NW +: NW]); // see R12
      end
    end
    for (int k = 0; k < B_N; k++) begin
      if (b_wr_strobe) begin
        mem[b_base + IW'(k)] <= (mem[b_base + IW'(k)] & ~b_mask[k*NW +: NW])
          | (b_wdata_q[k*NW +: NW] & b_mask[k*NW +: NW]); // see R2
      end
    end
  end

  // array read: gather narrow units into each port's width
  always_comb begin
    a_rd_raw = '0;
    b_rd_raw = '0;
    for (int k = 0; k < A_N; k++) begin
      a_rd_raw[k*NW +: NW] = mem[a_base + IW'(k)]; // see R9
    end
    for (int k = 0; k < B_N; k++) begin
      b_rd_raw[k*NW +: NW] = mem[b_base + IW'(k)]; // see R9
    end
  end

  // read during write of the same word: old data or all-ones fill
  wire same_word = (a_base >> WN_SH) == (b_base >> WN_SH);
  wire b_coll = !split && a_wr_strobe && b_re_q && same_word;
  wire a_coll = !split && b_wr_strobe && a_re_q && same_word;
  wire fill = IS_LARGE || !ctrl_old_reg; // see R7
  wire [A_W-1:0] a_rd_sel = (a_coll && fill) ? '1 : a_rd_raw; // see R7
  wire [B_W-1:0] b_rd_sel = (b_coll && fill) ? '1 : b_rd_raw; // see R7
  // single port reloads its output on writes too
  wire a_load = a_re_q || (EMODE == MODE_SINGLE && a_we_q); // see R8

  // output registers, cleared by reset on every size
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      a_rdata_reg <= '0; // see R14
      b_rdata_reg <= '0; // see R14
    end else begin
      a_rdata_reg <= a_load ? a_rd_sel : a_rdata_reg; // see R5 see R8
      b_rdata_reg <= b_re_q ? b_rd_sel : b_rdata_reg; // see R5
    end
  end

  // bypass exposes the array combinationally; flow-through forces it on port b
  assign a_rdata = OUT_REG ? a_rdata_reg : a_rd_sel; // see R5
  assign b_rdata = (OUT_REG && !FLOW) ? b_rdata_reg : b_rd_sel; // see R6

  // register bus: write address and data taken in either order
  logic awready_reg, wready_reg, bvalid_reg, arready_reg, rvalid_reg;
  logic [`RAM_AXI_AW-1:0] aw_addr_q;
  logic [31:0] w_data_q, rdata_reg;
  logic [3:0] w_strb_q;
  logic [1:0] bresp_reg, rresp_reg;
  wire aw_take = awvalid && awready_reg;
  wire w_take = wvalid && wready_reg;
  wire wr_go = !awready_reg && !wready_reg && !bvalid_reg;
  wire wr_ctrl = wr_go && aw_addr_q == `RAM_CTRL_OFS && w_strb_q[0];
  wire aw_hit = aw_addr_q == `RAM_CTRL_OFS ||
    aw_addr_q == `RAM_STATUS_OFS || aw_addr_q == `RAM_CONFIG_OFS;
  wire ar_take = arvalid && arready_reg;
  wire [31:0] cfg_word = {26'h0, FLOW, OUT_REG, 2'(EMODE), 2'(SIZE)};
  wire ar_ctrl = araddr == `RAM_CTRL_OFS;
  wire ar_stat = araddr == `RAM_STATUS_OFS;
  wire ar_cfg = araddr == `RAM_CONFIG_OFS;
  wire [31:0] rd_word = ar_ctrl ? {31'h0, ctrl_old_reg} :
    ar_stat ? {16'h0, coll_cnt_reg} : ar_cfg ? cfg_word : 32'h0;
  wire [1:0] rd_resp = (ar_ctrl || ar_stat || ar_cfg) ?
    `RAM_RESP_OKAY : `RAM_RESP_SLVERR;

  // write channel handshakes
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      awready_reg <= 1'b1;
      wready_reg <= 1'b1;
      bvalid_reg <= 1'b0;
      bresp_reg <= `RAM_RESP_OKAY;
      aw_addr_q <= '0;
      w_data_q <= 32'h0;
      w_strb_q <= 4'h0;
    end else begin
      if (aw_take) begin
        aw_addr_q <= awaddr;
        awready_reg <= 1'b0;
      end
      if (w_take) begin
        w_data_q <= wdata;
        w_strb_q <= wstrb;
        wready_reg <= 1'b0;
      end
      if (wr_go) begin
        bvalid_reg <= 1'b1;
        bresp_reg <= aw_hit ? `RAM_RESP_OKAY : `RAM_RESP_SLVERR;
      end else if (bvalid_reg && bready) begin
        bvalid_reg <= 1'b0;
        awready_reg <= 1'b1;
        wready_reg <= 1'b1;
      end
    end
  end

  // read channel: one read at a time, answered the cycle after take
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      arready_reg <= 1'b1;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0;
      rresp_reg <= `RAM_RESP_OKAY;
    end else if (ar_take) begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b1;
      rdata_reg <= rd_word;
      rresp_reg <= rd_resp;
    end else if (rvalid_reg && rready) begin
      rvalid_reg <= 1'b0;
      arready_reg <= 1'b1;
    end
  end

  // control bit and saturating count of read-during-write clashes
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_old_reg <= `RAM_CTRL_RESET;
      coll_cnt_reg <= '0;
    end else begin
      if (wr_ctrl) begin
        ctrl_old_reg <= w_data_q[`RAM_CTRL_OLD_BIT]; // see R7
      end
      if ((a_coll || b_coll) && coll_cnt_reg != '1) begin
        coll_cnt_reg <= coll_cnt_reg + 1'b1;
      end
    end
  end

  assign awready = awready_reg;
  assign wready = wready_reg;
  assign bvalid = bvalid_reg;
  assign bresp = bresp_reg;
  assign arready = arready_reg;
  assign rvalid = rvalid_reg;
  assign rdata = rdata_reg;
  assign rresp = rresp_reg;

  // checks on port behaviour
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);

  sequence s_a_wreq;
    a_wreq;
  endsequence
  sequence s_both_wreq;
    a_wreq && b_wreq;
  endsequence

  chk_input_capture: assert property ( // see R3
    s_a_wreq |=> a_we_q && a_addr_q == $past(a_addr))
    else $error("port a write request not captured");
  chk_strobe_timing: assert property ( // see R4
    a_wr_strobe |-> $past(a_wreq))
    else $error("write strobe without a captured request");
  chk_two_writes: assert property ( // see R2
    (EMODE == MODE_TRUE_DUAL) and s_both_wreq |=> a_wr_strobe && b_wr_strobe)
    else $error("true dual port lost a write");
  chk_out_reg_load: assert property ( // see R5
    (OUT_REG && a_re_q) |=> a_rdata == $past(a_rd_sel))
    else $error("registered read data wrong");
  chk_rdw_fill: assert property ( // see R7
    (b_coll && fill) |-> b_rd_sel == '1 ##1 (!OUT_REG || FLOW ||
      b_rdata == '1))
    else $error("clash did not return fill data");
  chk_single_idle: assert property ( // see R8
    (EMODE == MODE_SINGLE) |-> !b_we_q && !b_re_q)
    else $error("single port mode used port b");
  chk_split_halves: assert property ( // see R10
    split |-> !a_addr_eff[A_AW-1] && b_addr_eff[B_AW-1])
    else $error("split memories overlap");
  chk_clear_regs: assert property ( // see R14
    $rose(rst_b) |-> a_rdata_reg == '0 && (!CLR_IN || !a_we_q))
    else $error("clear left registers set");
  chk_flow_read: assert property ( // see R6
    (FLOW && b_re_q && !b_coll) |-> b_rdata == b_rd_raw)
    else $error("flow-through read not combinational");

endmodule // configurable_embedded_ram

// File: verification/fabric_user_model.sv
// fabric user logic that owns port b of the embedded ram
// assumes one shared rising-edge clock and a tb that calls b_req
`timescale 1ns/1ps
module fabric_user_model #(
  parameter int AW = 7,
  parameter int W = 36
) (
  input wire logic mclk,
  output logic b_clken,
  output logic [AW-1:0] b_addr,
  output logic [W-1:0] b_wdata,
  output logic [15:0] b_be,
  output logic b_we,
  output logic b_re
);
  // user side builds parity, one bit on top of each eight-bit byte
  function automatic logic [35:0] with_par(input logic [31:0] p);
    for (int i = 0; i < 4; i++) with_par[i*9+:9] = {^p[i*8+:8], p[i*8+:8]};
  endfunction
  initial begin
    b_clken = 1'b0;
    b_addr = '0;
    b_wdata = '0;
    b_be = 16'h0000;
    b_we = 1'b0;
    b_re = 1'b0;
  end
  // one request cycle; data pattern flips when idle so nothing stale passes
  task automatic b_req(input logic we, input logic re, input logic [6:0] ad,
                       input logic [31:0] pl, input logic [3:0] be);
    @(posedge mclk);
    b_clken <= 1'b1;
    b_we <= we;
    b_re <= re;
    b_addr <= ad;
    b_wdata <= with_par(pl);
    b_be <= {12'h000, be};
    @(posedge mclk);
    b_clken <= 1'b0;
    b_we <= 1'b0;
    b_re <= 1'b0;
    b_addr <= ~ad;
    b_wdata <= ~with_par(pl);
  endtask
endmodule // fabric_user_model

// File: verification/tb_top.sv
// self-checking bench for the configurable embedded ram, medium true dual
// assumes the ram design files and the fabric user model are compiled first
`timescale 1ns/1ps
module tb_top;
  import ram_types_pkg::*;
  logic mclk, rst_b, a_clken, a_we, a_re;
  logic [6:0] a_addr;
  logic [35:0] a_wdata, a_rdata, b_rdata, b_wdata;
  logic [15:0] a_be, b_be;
  logic b_clken, b_we, b_re;
  logic [6:0] b_addr;
  logic [11:0] awaddr, araddr;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [31:0] wdata, rdata, seed, rd;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, rs;
  logic [35:0] ref_mem [128];
  int mismatches, num_checks;
  configurable_embedded_ram dut (.mclk(mclk), .rst_b(rst_b),
    .a_clken(a_clken), .a_addr(a_addr), .a_wdata(a_wdata), .a_be(a_be),
    .a_we(a_we), .a_re(a_re), .a_rdata(a_rdata), .b_clken(b_clken),
    .b_addr(b_addr), .b_wdata(b_wdata), .b_be(b_be), .b_we(b_we),
    .b_re(b_re), .b_rdata(b_rdata), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready));
  fabric_user_model u_fab (.mclk(mclk), .b_clken(b_clken), .b_addr(b_addr),
    .b_wdata(b_wdata), .b_be(b_be), .b_we(b_we), .b_re(b_re));
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    lfsr = {s[30:0], 1'b0} ^ (s[31] ? 32'h04C11DB7 : 32'h0);
  endfunction
  function automatic logic [35:0] pw(input logic [31:0] p);
    for (int i = 0; i < 4; i++) pw[i*9+:9] = {^p[i*8+:8], p[i*8+:8]};
  endfunction
  task automatic chk(input string nm, input logic [35:0] e, input logic [35:0] g);
    num_checks++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // handshakes judged on the values sampled at each rising edge
  task automatic axi_wr(input logic [11:0] ad, input logic [31:0] d,
                        input logic [3:0] st, output logic [1:0] r);
    logic ad_ok, wd_ok;
    ad_ok = 0;
    wd_ok = 0;
    @(posedge mclk);
    awaddr <= ad; wdata <= d; wstrb <= st;
    awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    while (!(ad_ok && wd_ok)) begin
      @(posedge mclk);
      if (awvalid && awready) begin awvalid <= 1'b0; ad_ok = 1; end
      if (wvalid && wready) begin wvalid <= 1'b0; wd_ok = 1; end
    end
    do @(posedge mclk); while (!bvalid);
    r = bresp;
    bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [11:0] ad, output logic [31:0] d,
                        output logic [1:0] r);
    @(posedge mclk);
    araddr <= ad; arvalid <= 1'b1; rready <= 1'b1;
    do @(posedge mclk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge mclk); while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
  task automatic a_req(input logic we, input logic re, input logic [6:0] ad,
                       input logic [31:0] pl, input logic [3:0] be);
    @(posedge mclk);
    a_clken <= 1'b1; a_we <= we; a_re <= re; a_addr <= ad;
    a_wdata <= pw(pl); a_be <= {12'h000, be};
    @(posedge mclk);
    a_clken <= 1'b0; a_we <= 1'b0; a_re <= 1'b0; a_wdata <= ~pw(pl);
  endtask
  // expected word after a lane-masked write
  function automatic logic [35:0] merge(input logic [35:0] o,
                                        input logic [31:0] p, input logic [3:0] be);
    logic [35:0] np;
    np = pw(p);
    merge = o;
    for (int i = 0; i < 4; i++) if (be[i]) merge[i*9+:9] = np[i*9+:9];
  endfunction
  // write one word, then read it through both ports in the same cycle
  task automatic traffic(input logic [6:0] ad, input logic [31:0] p,
                         input logic [3:0] be, input logic via_b);
    if (via_b) u_fab.b_req(1, 0, ad, p, be);
    else a_req(1, 0, ad, p, be);
    ref_mem[ad] = merge(ref_mem[ad], p, be);
    fork
      a_req(0, 1, ad, 0, 0);
      u_fab.b_req(0, 1, ad, 0, 0);
    join
    @(posedge mclk);
    #1;
    chk("a_rdata", ref_mem[ad], a_rdata);
    chk("b_rdata", ref_mem[ad], b_rdata);
  endtask
  // read and write of one address launched in the same cycle
  task automatic clash(input logic [6:0] ad, input logic [35:0] e);
    seed = lfsr(seed);
    fork
      a_req(1, 0, ad, seed, 4'hF);
      u_fab.b_req(0, 1, ad, 0, 0);
    join
    @(posedge mclk);
    #1;
    chk("clash b_rdata", e, b_rdata);
    ref_mem[ad] = pw(seed);
  endtask
  initial begin
    mismatches = 0; num_checks = 0; seed = 32'hbf04f4d1;
    rst_b = 1'b0; a_clken = 0; a_we = 0; a_re = 0; a_addr = '0;
    a_wdata = '0; a_be = '0; awaddr = '0; awvalid = 0; wdata = '0;
    wstrb = '0; wvalid = 0; bready = 0; araddr = '0; arvalid = 0; rready = 0;
    repeat (10) @(posedge mclk);
    chk("a_rdata reset", 36'h0, a_rdata);
    chk("b_rdata reset", 36'h0, b_rdata);
    rst_b <= 1'b1;
    axi_rd(12'h008, rd, rs);
    chk("config", 32'h11, rd);
    axi_wr(12'h000, 32'h1, 4'h0, rs);
    axi_rd(12'h000, rd, rs);
    chk("ctrl no strobe", 32'h0, rd);
    axi_wr(12'h010, 32'h1, 4'hF, rs);
    chk("unmapped bresp", 2'h2, rs);
    axi_rd(12'h002, rd, rs);
    chk("misaligned rresp", 2'h2, rs);
    chk("misaligned rdata", 32'h0, rd);
    // fill every word once so later reads have a known value
    for (int i = 0; i < 128; i++) begin
      seed = lfsr(seed);
      a_req(1, 0, i[6:0], seed, 4'hF);
      ref_mem[i] = pw(seed);
    end
    // random addresses, lanes and write port, with lane masks 0 and F among them
    for (int i = 0; i < 60; i++) begin
      seed = lfsr(seed);
      rd = seed;
      seed = lfsr(seed);
      traffic(rd[6:0], seed, (i < 2) ? {4{i[0]}} : rd[11:8], rd[12]);
    end
    traffic(7'h7F, 32'hFFFF0000, 4'h5, 1'b1);
    axi_wr(12'h000, 32'h1, 4'h1, rs);
    clash(7'h11, ref_mem[7'h11]);
    axi_wr(12'h000, 32'h0, 4'h1, rs);
    clash(7'h22, 36'hFFFFFFFFF);
    traffic(7'h22, 32'hA5A5A5A5, 4'hF, 1'b0);
    axi_wr(12'h004, 32'h0, 4'hF, rs);
    chk("status write bresp", 2'h0, rs);
    axi_rd(12'h004, rd, rs);
    chk("clash count", 32'h2, rd);
    axi_wr(12'h000, 32'h1, 4'h1, rs);
    // asynchronous clear in mid-run; outputs drop without waiting an edge
    @(posedge mclk);
    rst_b <= 1'b0;
    #1;
    chk("a_rdata clear", 36'h0, a_rdata);
    chk("b_rdata clear", 36'h0, b_rdata);
    @(posedge mclk);
    rst_b <= 1'b1;
    axi_rd(12'h000, rd, rs);
    chk("ctrl after clear", 32'h0, rd);
    finish_test();
  end
  // the whole sequence needs well under 5000 cycles
  initial begin
    #200000;
    mismatches++;
    finish_test();
  end
endmodule // tb_top
